// ### src/mtwr_top.sv
`timescale 1ns/1ns
module mtwr_top
    import mtwr_pkg::*;
#(
    parameter int WD_BASE_BITS = 17
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic rst_pin,
    input wire logic timer0_ext_input,
    input wire logic timer1_ext_input,
    input wire logic timer2_ext_input,
    input wire logic ext_irq0_n,
    input wire logic ext_irq1_n,
    input wire logic uart_rx_done_flag,
    input wire logic uart_tx_done_flag,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd,
    input wire logic irq_ack,
    output logic [7:0] sfr_rdata,
    output logic sys_reset,
    output logic irq_req,
    output logic [7:0] irq_vector,
    output logic irq_high_prio
);

    localparam int WD_W = WD_BASE_BITS + 3 * WD_TAP_STEP;

    typedef struct packed {
        logic [7:0] timer_control_flags;
        logic [7:0] timer_mode_config;
        logic [7:0] timer2_control;
        logic [7:0] timer2_mode_config;
        logic [7:0] ckcon;
        logic [7:0] ie;
        logic [7:0] ip;
        logic [7:0] eie;
        logic [7:0] eip;
        logic [7:0] wdcon;
        logic [2:0][15:0] cnt;
        logic [2:0] t_smp;
        logic [2:0] t_pend;
        logic [1:0] int_smp;
        logic [WD_W-1:0] wd_cnt;
        logic wd_arm;
        logic [9:0] wd_dly;
        logic [3:0] hold;
        logic sys_reset;
        logic irq_req;
        logic [7:0] irq_vec;
        logic irq_hi;
        logic [7:0] rdata;
    } mtwr_state_t;

    mtwr_state_t s_q;
    mtwr_state_t s_d;
    logic c3;
    logic c4;
    logic slow_tick;

    mtwr_phase u_phase (
        .clk(clk),
        .reset_n(reset_n),
        .c3(c3),
        .c4(c4),
        .slow_tick(slow_tick)
    );

    always_comb begin
        logic [2:0] pin;
        logic [2:0] run;
        logic [2:0] cmode;
        logic [2:0] wr_hit;
        logic [2:0] ovf;
        logic [6:0] req;
        logic [6:0] en;
        logic [6:0] pri;
        logic [1:0] ipin;
        logic [WD_W-1:0] wd_mask;
        logic wd_timeout;
        logic wd_fire;
        logic rst_req;
        logic found;
        logic [7:0] vec;
        logic hi;
        s_d = s_q;
        pin = {timer2_ext_input, timer1_ext_input, timer0_ext_input};
        ipin = {ext_irq1_n, ext_irq0_n};
        wr_hit = 3'h0;
        ovf = 3'h0;
        found = 1'b0;
        vec = 8'h00;
        hi = 1'b0;
        run = {s_q.timer2_control[B_TIMER2_RUN], s_q.timer_control_flags[B_TIMER1_RUN], s_q.timer_control_flags[B_TIMER0_RUN]};
        cmode = {s_q.timer2_control[B_TIMER2_SOURCE_SELECT], s_q.timer_mode_config[B_TIMER1_COUNTER_SEL],
                 s_q.timer_mode_config[B_TIMER0_COUNTER_SEL]};
        wd_mask = ~({WD_W{1'b1}} << (WD_BASE_BITS + WD_TAP_STEP * int'(s_q.wdcon[B_WDOG_INTERVAL_LO +: 2])));
        wd_timeout = ((s_q.wd_cnt & wd_mask) == wd_mask);
        wd_fire = s_q.wd_arm && s_q.wdcon[B_WDOG_RESET_ENABLE] && (s_q.wd_dly == WD_DLY_LAST);
        req = {s_q.wdcon[B_WATCHDOG_TIMEOUT_FLAG],
               s_q.timer2_control[B_TIMER2_OVERFLOW_FLAG] | s_q.timer2_control[B_TIMER2_EXT_FLAG],
               uart_rx_done_flag | uart_tx_done_flag,
               s_q.timer_control_flags[B_TIMER1_OVERFLOW_FLAG], s_q.timer_control_flags[B_EXT_IRQ1_FLAG],
               s_q.timer_control_flags[B_TIMER0_OVERFLOW_FLAG], s_q.timer_control_flags[B_EXT_IRQ0_FLAG]};
        en = {s_q.eie[B_WDOG_IRQ_BIT], s_q.ie[5:0]} & {7{s_q.ie[B_GLOBAL_IRQ_ENABLE]}};
        pri = {s_q.eip[B_WDOG_IRQ_BIT], s_q.ip[5:0]};
        rst_req = c4 && rst_pin;

        // Register writes
        if (sfr_wr) begin
            unique case (sfr_addr)
                ADDR_TIMER_CONTROL_FLAGS: s_d.timer_control_flags = sfr_wdata;
                ADDR_TIMER_MODE_CONFIG: s_d.timer_mode_config = sfr_wdata;
                ADDR_TIMER0_COUNT_LOW: begin
                    s_d.cnt[0][7:0] = sfr_wdata;
                    wr_hit[0] = 1'b1;
                end
                ADDR_TIMER1_COUNT_LOW: begin
                    s_d.cnt[1][7:0] = sfr_wdata;
                    wr_hit[1] = 1'b1;
                end
                ADDR_TIMER0_COUNT_HIGH: begin
                    s_d.cnt[0][15:8] = sfr_wdata;
                    wr_hit[0] = 1'b1;
                end
                ADDR_TIMER1_COUNT_HIGH: begin
                    s_d.cnt[1][15:8] = sfr_wdata;
                    wr_hit[1] = 1'b1;
                end
                ADDR_TIMER2_COUNT_LOW: begin
                    s_d.cnt[2][7:0] = sfr_wdata;
                    wr_hit[2] = 1'b1;
                end
                ADDR_TIMER2_COUNT_HIGH: begin
                    s_d.cnt[2][15:8] = sfr_wdata;
                    wr_hit[2] = 1'b1;
                end
                ADDR_CLOCK_CTRL: s_d.ckcon = sfr_wdata;
                ADDR_IRQ_ENABLE: s_d.ie = sfr_wdata;
                ADDR_IRQ_PRIORITY: s_d.ip = sfr_wdata;
                ADDR_TIMER2_CONTROL: s_d.timer2_control = sfr_wdata;
                ADDR_TIMER2_MODE_CONFIG: s_d.timer2_mode_config = sfr_wdata & TIMER2_MODE_MASK;
                ADDR_WDOG_CTRL: s_d.wdcon = (s_q.wdcon & ~WDOG_CTRL_RW_MASK) | (sfr_wdata & WDOG_CTRL_RW_MASK)
                    & ~(8'h1 << B_WATCHDOG_TIMEOUT_FLAG) & ~(8'h1 << B_WDOG_RESET_FLAG)
                    | (s_q.wdcon & sfr_wdata & 8'h0c);
                ADDR_IRQ_ENABLE_EXT: s_d.eie = sfr_wdata;
                ADDR_IRQ_PRIORITY_EXT: s_d.eip = sfr_wdata;
                default: ;
            endcase
        end

        // Acknowledge clears the served flag for timer 0/1 overflow or edge-mode external interrupts 0/1 only
        if (irq_ack && s_q.irq_req) begin
            if (s_q.irq_vec == IRQ_VECTORS[0] && s_q.timer_control_flags[B_EXT_IRQ0_EDGE_SELECT]) begin
                s_d.timer_control_flags[B_EXT_IRQ0_FLAG] = 1'b0;
            end
            if (s_q.irq_vec == IRQ_VECTORS[1]) begin
                s_d.timer_control_flags[B_TIMER0_OVERFLOW_FLAG] = 1'b0;
            end
            if (s_q.irq_vec == IRQ_VECTORS[2] && s_q.timer_control_flags[B_EXT_IRQ1_EDGE_SELECT]) begin
                s_d.timer_control_flags[B_EXT_IRQ1_FLAG] = 1'b0;
            end
            if (s_q.irq_vec == IRQ_VECTORS[3]) begin
                s_d.timer_control_flags[B_TIMER1_OVERFLOW_FLAG] = 1'b0;
            end
        end

        // External interrupt inputs: edge latches, level follows pin
        s_d.int_smp = ipin;
        if (s_q.timer_control_flags[B_EXT_IRQ0_EDGE_SELECT]) begin
            if (s_q.int_smp[0] && !ipin[0]) begin
                s_d.timer_control_flags[B_EXT_IRQ0_FLAG] = 1'b1;
            end
        end else begin
            s_d.timer_control_flags[B_EXT_IRQ0_FLAG] = !ipin[0];
        end
        if (s_q.timer_control_flags[B_EXT_IRQ1_EDGE_SELECT]) begin
            if (s_q.int_smp[1] && !ipin[1]) begin
                s_d.timer_control_flags[B_EXT_IRQ1_FLAG] = 1'b1;
            end
        end else begin
            s_d.timer_control_flags[B_EXT_IRQ1_FLAG] = !ipin[1];
        end

        // Timers 0, 1, 2
        for (int i = 0; i < 3; i++) begin
            if (c4) begin
                s_d.t_smp[i] = pin[i];
                s_d.t_pend[i] = s_q.t_smp[i] && !pin[i];
            end else if (c3) begin
                s_d.t_pend[i] = 1'b0;
            end
            if (c3 && run[i] && !wr_hit[i]) begin
                if (cmode[i] ? s_q.t_pend[i] : (s_q.ckcon[B_CLK_DIV4_BASE + i] || slow_tick)) begin
                    s_d.cnt[i] = s_q.cnt[i] + 16'h1;
                    ovf[i] = (s_q.cnt[i] == 16'hffff);
                end
            end
        end
        if (ovf[0]) begin
            s_d.timer_control_flags[B_TIMER0_OVERFLOW_FLAG] = 1'b1;
        end
        if (ovf[1]) begin
            s_d.timer_control_flags[B_TIMER1_OVERFLOW_FLAG] = 1'b1;
        end
        if (ovf[2]) begin
            s_d.timer2_control[B_TIMER2_OVERFLOW_FLAG] = 1'b1;
        end

        // Watchdog divider chain, runs in idle as well
        s_d.wd_cnt = s_q.wd_cnt + WD_W'(1);
        s_d.wd_dly = s_q.wd_dly + 10'h1;
        if (wd_timeout) begin
            s_d.wdcon[B_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
            if (s_q.wdcon[B_WDOG_RESET_ENABLE] && !s_q.wd_arm) begin
                s_d.wd_arm = 1'b1;
                s_d.wd_dly = 10'h0;
            end
        end
        if (sfr_wr && sfr_addr == ADDR_WDOG_CTRL && sfr_wdata[B_WATCHDOG_RESTART_BIT]) begin
            s_d.wd_cnt = '0;
            s_d.wd_arm = 1'b0;
        end
        if (wd_fire) begin
            s_d.wd_arm = 1'b0;
        end

        // Interrupt request selection
        for (int i = IRQ_SOURCES - 1; i >= 0; i--) begin
            if (req[i] && en[i] && (pri[i] || !hi)) begin
                found = 1'b1;
                vec = IRQ_VECTORS[i];
                hi = pri[i];
            end
        end
        s_d.irq_req = found;
        s_d.irq_vec = vec;
        s_d.irq_hi = hi;

        // Reset recognition and hold
        if (rst_req || wd_fire) begin
            s_d.hold = RST_HOLD_CLKS;
        end else if (s_q.hold != 4'h0) begin
            s_d.hold = s_q.hold - 4'h1;
        end
        if (s_q.hold != 4'h0) begin
            s_d.timer_control_flags = SFR_RESET_VAL;
            s_d.timer_mode_config = SFR_RESET_VAL;
            s_d.timer2_control = SFR_RESET_VAL;
            s_d.timer2_mode_config = SFR_RESET_VAL;
            s_d.ckcon = SFR_RESET_VAL;
            s_d.ie = SFR_RESET_VAL;
            s_d.ip = SFR_RESET_VAL;
            s_d.eie = SFR_RESET_VAL;
            s_d.eip = SFR_RESET_VAL;
            s_d.wdcon = SFR_RESET_VAL | (s_q.wdcon & (8'h1 << B_WDOG_RESET_FLAG));
            s_d.cnt = '0;
            s_d.t_pend = 3'h0;
            s_d.wd_cnt = '0;
            s_d.wd_arm = 1'b0;
            s_d.irq_req = 1'b0;
            s_d.irq_vec = 8'h00;
            s_d.irq_hi = 1'b0;
        end
        if (wd_fire) begin
            s_d.wdcon[B_WDOG_RESET_FLAG] = 1'b1;
        end else if (rst_req) begin
            s_d.wdcon[B_WDOG_RESET_FLAG] = 1'b0;
        end
        s_d.sys_reset = (s_d.hold != 4'h0);

        // Read data
        if (sfr_rd) begin
            unique case (sfr_addr)
                ADDR_TIMER_CONTROL_FLAGS: s_d.rdata = s_q.timer_control_flags;
                ADDR_TIMER_MODE_CONFIG: s_d.rdata = s_q.timer_mode_config;
                ADDR_TIMER0_COUNT_LOW: s_d.rdata = s_q.cnt[0][7:0];
                ADDR_TIMER1_COUNT_LOW: s_d.rdata = s_q.cnt[1][7:0];
                ADDR_TIMER0_COUNT_HIGH: s_d.rdata = s_q.cnt[0][15:8];
                ADDR_TIMER1_COUNT_HIGH: s_d.rdata = s_q.cnt[1][15:8];
                ADDR_TIMER2_COUNT_LOW: s_d.rdata = s_q.cnt[2][7:0];
                ADDR_TIMER2_COUNT_HIGH: s_d.rdata = s_q.cnt[2][15:8];
                ADDR_CLOCK_CTRL: s_d.rdata = s_q.ckcon;
                ADDR_IRQ_ENABLE: s_d.rdata = s_q.ie;
                ADDR_IRQ_PRIORITY: s_d.rdata = s_q.ip;
                ADDR_TIMER2_CONTROL: s_d.rdata = s_q.timer2_control;
                ADDR_TIMER2_MODE_CONFIG: s_d.rdata = s_q.timer2_mode_config;
                ADDR_WDOG_CTRL: s_d.rdata = s_q.wdcon;
                ADDR_IRQ_ENABLE_EXT: s_d.rdata = s_q.eie;
                ADDR_IRQ_PRIORITY_EXT: s_d.rdata = s_q.eip;
                default: s_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sfr_rdata = s_q.rdata;
    assign sys_reset = s_q.sys_reset;
    assign irq_req = s_q.irq_req;
    assign irq_vector = s_q.irq_vec;
    assign irq_high_prio = s_q.irq_hi;

endmodule : mtwr_top

// ### src/mtwr_pkg.sv
package mtwr_pkg;

    // Machine cycle and phase timing
    localparam int CLKS_PER_MCYCLE = 4;
    localparam int MCYCLES_PER_SLOW_TICK = 3;
    localparam logic [1:0] PHASE_C3 = 2'h2;
    localparam logic [1:0] PHASE_LAST = 2'h3;
    localparam logic [1:0] SLOW_TICK_LAST = 2'(MCYCLES_PER_SLOW_TICK - 1);

    // Reset hold and watchdog reset delay
    localparam int RST_HOLD_MCYCLES = 2;
    localparam logic [3:0] RST_HOLD_CLKS = 4'(RST_HOLD_MCYCLES * CLKS_PER_MCYCLE);
    localparam int WD_RESET_DELAY_CLKS = 512;
    localparam logic [9:0] WD_DLY_LAST = 10'(WD_RESET_DELAY_CLKS - 1);
    localparam int WD_TAP_STEP = 3;
    localparam logic [15:0] RESET_PC = 16'h0000;

    // Register offsets
    localparam logic [7:0] ADDR_TIMER_CONTROL_FLAGS = 8'h88;
    localparam logic [7:0] ADDR_TIMER_MODE_CONFIG = 8'h89;
    localparam logic [7:0] ADDR_TIMER0_COUNT_LOW = 8'h8a;
    localparam logic [7:0] ADDR_TIMER1_COUNT_LOW = 8'h8b;
    localparam logic [7:0] ADDR_TIMER0_COUNT_HIGH = 8'h8c;
    localparam logic [7:0] ADDR_TIMER1_COUNT_HIGH = 8'h8d;
    localparam logic [7:0] ADDR_CLOCK_CTRL = 8'h8e;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'ha8;
    localparam logic [7:0] ADDR_IRQ_PRIORITY = 8'hb8;
    localparam logic [7:0] ADDR_TIMER2_CONTROL = 8'hc8;
    localparam logic [7:0] ADDR_TIMER2_MODE_CONFIG = 8'hc9;
    localparam logic [7:0] ADDR_TIMER2_COUNT_LOW = 8'hcc;
    localparam logic [7:0] ADDR_TIMER2_COUNT_HIGH = 8'hcd;
    localparam logic [7:0] ADDR_WDOG_CTRL = 8'hd8;
    localparam logic [7:0] ADDR_IRQ_ENABLE_EXT = 8'he8;
    localparam logic [7:0] ADDR_IRQ_PRIORITY_EXT = 8'hf8;

    // timer_control_flags fields
    localparam int B_TIMER1_OVERFLOW_FLAG = 7;
    localparam int B_TIMER1_RUN = 6;
    localparam int B_TIMER0_OVERFLOW_FLAG = 5;
    localparam int B_TIMER0_RUN = 4;
    localparam int B_EXT_IRQ1_FLAG = 3;
    localparam int B_EXT_IRQ1_EDGE_SELECT = 2;
    localparam int B_EXT_IRQ0_FLAG = 1;
    localparam int B_EXT_IRQ0_EDGE_SELECT = 0;
    // timer_mode_config counter selects
    localparam int B_TIMER0_COUNTER_SEL = 2;
    localparam int B_TIMER1_COUNTER_SEL = 6;
    // timer2_control fields
    localparam int B_TIMER2_OVERFLOW_FLAG = 7;
    localparam int B_TIMER2_EXT_FLAG = 6;
    localparam int B_TIMER2_RUN = 2;
    localparam int B_TIMER2_SOURCE_SELECT = 1;
    localparam logic [7:0] TIMER2_MODE_MASK = 8'h09;
    // clock_ctrl: divide-by-4 select per timer
    localparam int B_CLK_DIV4_BASE = 3;
    // wdog_ctrl fields
    localparam int B_WATCHDOG_RESTART_BIT = 0;
    localparam int B_WDOG_RESET_ENABLE = 1;
    localparam int B_WDOG_RESET_FLAG = 2;
    localparam int B_WATCHDOG_TIMEOUT_FLAG = 3;
    localparam int B_WDOG_INTERVAL_LO = 4;
    localparam logic [7:0] WDOG_CTRL_RW_MASK = 8'h3e;
    // irq enable / priority fields
    localparam int B_GLOBAL_IRQ_ENABLE = 7;
    localparam int B_WDOG_IRQ_BIT = 4;

    localparam logic [7:0] SFR_RESET_VAL = 8'h00;

    // Interrupt sources in natural priority order, highest at index 0 (8'h03), lowest at index 6 (8'h63)
    localparam int IRQ_SOURCES = 7;
    localparam logic [IRQ_SOURCES-1:0][7:0] IRQ_VECTORS =
        {8'h63, 8'h2b, 8'h23, 8'h1b, 8'h13, 8'h0b, 8'h03};

endpackage : mtwr_pkg

// ### src/mtwr_phase.sv
`timescale 1ns/1ns
module mtwr_phase
    import mtwr_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    output logic c3,
    output logic c4,
    output logic slow_tick
);

    typedef struct packed {
        logic [1:0] phase;
        logic [1:0] mcyc;
        logic c3;
        logic c4;
        logic slow;
    } mtwr_phase_t;

    mtwr_phase_t s_q;
    mtwr_phase_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.phase = s_q.phase + 2'h1;
        if (s_q.phase == PHASE_LAST) begin
            s_d.mcyc = (s_q.mcyc == SLOW_TICK_LAST) ? 2'h0 : s_q.mcyc + 2'h1;
        end
        s_d.c3 = (s_d.phase == PHASE_C3);
        s_d.c4 = (s_d.phase == PHASE_LAST);
        s_d.slow = s_d.c3 && (s_d.mcyc == 2'h0);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign c3 = s_q.c3;
    assign c4 = s_q.c4;
    assign slow_tick = s_q.slow;

endmodule : mtwr_phase

// ### tb/mtwr_assertions.sv
`timescale 1ns/1ns
module mtwr_assertions
    import mtwr_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic rst_pin,
    input wire logic sfr_rd,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic sys_reset,
    input wire logic irq_req,
    input wire logic [7:0] irq_vector,
    input wire logic irq_high_prio
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    chk_pin_detect: assert property (rst_pin [*8] |-> sys_reset)
        else $error("reset pin held high but no reset");
    chk_reset_hold: assert property ($rose(sys_reset) |-> sys_reset [*8])
        else $error("reset shorter than two machine cycles");
    chk_reset_len: assert property ($fell(sys_reset) && !$past(rst_pin, 9) |-> $past(sys_reset, 8))
        else $error("reset dropped early");
    chk_rdata_hold: assert property (!$past(sfr_rd) && !$past(sys_reset) && !$past(sys_reset, 2)
        |-> $stable(sfr_rdata))
        else $error("read data changed without a read");
    chk_unmapped_zero: assert property (sfr_rd && sfr_addr == 8'h80 |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_vector_legal: assert property (irq_req |-> irq_vector inside
        {8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h2b, 8'h63})
        else $error("illegal vector");
    chk_global_gate: assert property (sfr_wr && sfr_addr == ADDR_IRQ_ENABLE && !sfr_wdata[7]
        |-> ##3 !irq_req)
        else $error("request with global enable off");
    chk_prio_req: assert property (irq_high_prio |-> irq_req)
        else $error("priority flag without request");
    chk_reset_irq: assert property (sys_reset [*2] |=> !irq_req)
        else $error("request during reset");

    cover property ($rose(sys_reset) && !rst_pin);
    cover property (irq_req && irq_high_prio);
    cover property (irq_req && irq_vector == 8'h63);
endmodule : mtwr_assertions

// ### tb/mtwr_core_model.sv
`timescale 1ns/1ns
module mtwr_core_model (
    input wire logic clk,
    input wire logic [7:0] sfr_rdata,
    output logic [7:0] sfr_addr,
    output logic sfr_wr,
    output logic [7:0] sfr_wdata,
    output logic sfr_rd,
    output logic irq_ack,
    output logic rst_pin,
    output logic [2:0] cnt_in
);
    initial begin
        {sfr_addr, sfr_wr, sfr_wdata, sfr_rd, irq_ack, rst_pin} = '0;
        cnt_in = 3'h7;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
        sfr_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clk);
        sfr_rd = 1'b0;
        d = sfr_rdata;
    endtask : rd
    task automatic pulses(input int t, input int n);
        repeat (n) begin
            cnt_in[t] = 1'b0;
            repeat (8) @(negedge clk);
            cnt_in[t] = 1'b1;
            repeat (8) @(negedge clk);
        end
    endtask : pulses
    task automatic rst_hold(input int n);
        @(negedge clk);
        rst_pin = 1'b1;
        repeat (n) @(negedge clk);
        rst_pin = 1'b0;
    endtask : rst_hold
    task automatic ack();
        @(negedge clk);
        irq_ack = 1'b1;
        @(negedge clk);
        irq_ack = 1'b0;
    endtask : ack
endmodule : mtwr_core_model

// ### tb/tb.sv
`timescale 1ns/1ns
module tb;
    import mtwr_pkg::*;
    logic clk, reset_n, rst_pin, ext_irq0_n, ext_irq1_n, uart_rx, uart_tx, sfr_wr, sfr_rd, irq_ack;
    logic sys_reset, irq_req, irq_high_prio;
    logic [2:0] cnt_in;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, irq_vector, d;
    int n_errors = 0;
    int n_checks = 0;
    int n, c;
    int exp_q[$];
    logic [7:0] lo_a[3] = '{8'h8a, 8'h8b, 8'hcc};
    logic [7:0] hi_a[3] = '{8'h8c, 8'h8d, 8'hcd};
    logic [7:0] ct_a[3] = '{8'h88, 8'h88, 8'hc8};
    logic [7:0] run_m[3] = '{8'h10, 8'h40, 8'h04};
    logic [7:0] flg_m[3] = '{8'h20, 8'h80, 8'h80};
    logic [7:0] rv_a[14] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h8e, 8'ha8, 8'hb8, 8'hc8, 8'hc9,
        8'hcc, 8'hcd, 8'hf8};

    mtwr_top #(.WD_BASE_BITS(4)) i_dut (.clk(clk), .reset_n(reset_n), .rst_pin(rst_pin),
        .timer0_ext_input(cnt_in[0]), .timer1_ext_input(cnt_in[1]), .timer2_ext_input(cnt_in[2]),
        .ext_irq0_n(ext_irq0_n), .ext_irq1_n(ext_irq1_n), .uart_rx_done_flag(uart_rx),
        .uart_tx_done_flag(uart_tx), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
        .sfr_rd(sfr_rd), .irq_ack(irq_ack), .sfr_rdata(sfr_rdata), .sys_reset(sys_reset),
        .irq_req(irq_req), .irq_vector(irq_vector), .irq_high_prio(irq_high_prio));
    mtwr_core_model i_core (.clk(clk), .sfr_rdata(sfr_rdata), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .irq_ack(irq_ack), .rst_pin(rst_pin), .cnt_in(cnt_in));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
        logic [7:0] v;
        i_core.rd(a, v);
        chk(v & m, exp, "register read");
    endtask : rchk
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        #(8 * 40000);
        n_errors++;
        $display("Error %0t: run hung", $time);
        finish_test();
    end
    initial begin
        reset_n = 1'b0;
        ext_irq0_n = 1'b1;
        ext_irq1_n = 1'b1;
        uart_rx = 1'b0;
        uart_tx = 1'b0;
        void'($urandom(32'hd8be));
        repeat (20) @(negedge clk);
        reset_n = 1'b1;
        foreach (rv_a[i]) rchk(rv_a[i], SFR_RESET_VAL, 8'hff);
        d = 8'($urandom());
        i_core.wr(8'h89, d);
        rchk(8'h89, d, 8'hff);
        i_core.wr(8'hc9, ~d);
        rchk(8'hc9, ~d & TIMER2_MODE_MASK, 8'hff);
        i_core.wr(8'h80, d);
        rchk(8'h80, 8'h00, 8'hff);
        i_core.wr(8'h89, 8'h00);
        $display("registers done");
        for (int t = 0; t < 3; t++) begin
            for (int k = 0; k < 2; k++) begin
                n = k ? 4 : 12;
                i_core.wr(8'h8e, k ? (8'h08 << t) : 8'h00);
                i_core.wr(hi_a[t], 8'hff);
                i_core.wr(lo_a[t], 8'hfa);
                i_core.wr(ct_a[t], run_m[t]);
                repeat (5 * n - 4) @(negedge clk);
                rchk(ct_a[t], 8'h00, flg_m[t]);
                repeat (2 * n + 4) @(negedge clk);
                rchk(ct_a[t], flg_m[t], flg_m[t]);
                i_core.wr(ct_a[t], 8'h00);
            end
        end
        i_core.rd(8'hcc, d);
        repeat (40) @(negedge clk);
        rchk(8'hcc, d, 8'hff);
        $display("timer mode done");
        for (int t = 0; t < 3; t++) begin
            i_core.wr(8'h89, (t == 1) ? 8'h40 : 8'h04);
            i_core.wr(lo_a[t], 8'h00);
            i_core.wr(ct_a[t], run_m[t] | ((t == 2) ? 8'h02 : 8'h00));
            exp_q.push_back($urandom_range(6, 2));
            i_core.pulses(t, exp_q[$]);
            repeat (8) @(negedge clk);
            rchk(lo_a[t], 8'(exp_q.pop_front()), 8'hff);
            i_core.wr(ct_a[t], 8'h00);
        end
        i_core.wr(8'h89, 8'h00);
        $display("counter mode done");
        i_core.wr(8'hd8, 8'h00);
        repeat (20) @(negedge clk);
        rchk(8'hd8, 8'h08, 8'h08);
        ext_irq0_n = 1'b0;
        ext_irq1_n = 1'b0;
        uart_rx = 1'b1;
        i_core.wr(8'h88, 8'ha0);
        i_core.wr(8'hc8, 8'h80);
        for (int i = 0; i < IRQ_SOURCES; i++) begin
            i_core.wr(8'ha8, 8'h80 | ((i < 6) ? 8'(1 << i) : 8'h00));
            i_core.wr(8'he8, (i == 6) ? 8'h10 : 8'h00);
            repeat (3) @(negedge clk);
            chk({7'h00, irq_req}, 8'h01, "request");
            chk(irq_vector, IRQ_VECTORS[i], "vector");
        end
        i_core.wr(8'ha8, 8'hbf);
        i_core.wr(8'hb8, 8'h08);
        repeat (3) @(negedge clk);
        chk(irq_vector, 8'h1b, "priority vector");
        chk({7'h00, irq_high_prio}, 8'h01, "priority level");
        i_core.wr(8'hb8, 8'h00);
        repeat (3) @(negedge clk);
        chk(irq_vector, 8'h03, "natural order");
        uart_rx = 1'b0;
        uart_tx = 1'b1;
        i_core.wr(8'ha8, 8'h90);
        repeat (3) @(negedge clk);
        chk(irq_vector, 8'h23, "serial transmit");
        i_core.wr(8'ha8, 8'h3f);
        repeat (4) @(negedge clk);
        chk({7'h00, irq_req}, 8'h00, "global off");
        ext_irq0_n = 1'b1;
        ext_irq1_n = 1'b1;
        uart_tx = 1'b0;
        i_core.wr(8'hc8, 8'h00);
        i_core.wr(8'he8, 8'h00);
        i_core.wr(8'ha8, 8'h82);
        repeat (3) @(negedge clk);
        chk(irq_vector, 8'h0b, "timer vector");
        i_core.ack();
        rchk(8'h88, 8'h00, 8'h20);
        i_core.wr(8'h88, 8'h01);
        i_core.wr(8'ha8, 8'h81);
        ext_irq0_n = 1'b0;
        repeat (2) @(negedge clk);
        ext_irq0_n = 1'b1;
        repeat (3) @(negedge clk);
        chk(irq_vector, 8'h03, "edge vector");
        chk({7'h00, irq_req}, 8'h01, "edge latched");
        i_core.ack();
        rchk(8'h88, 8'h00, 8'h02);
        i_core.wr(8'ha8, 8'h00);
        $display("interrupts done");
        i_core.wr(8'hd8, 8'h03);
        c = 0;
        while (sys_reset !== 1'b1 && c < 1000) begin
            @(negedge clk);
            c++;
        end
        chk(8'(c >= 513 && c <= 540), 8'h01, "watchdog delay");
        c = 0;
        while (sys_reset === 1'b1 && c < 20) begin
            @(negedge clk);
            c++;
        end
        chk(8'(c), 8'h08, "watchdog hold");
        repeat (2) @(negedge clk);
        rchk(8'hd8, 8'h04, 8'h06);
        c = 0;
        repeat (8) begin
            i_core.wr(8'hd8, 8'h03);
            repeat (98) begin
                @(negedge clk);
                c += (sys_reset !== 1'b0);
            end
        end
        chk(8'(c), 8'h00, "restart cancels");
        i_core.wr(8'hd8, 8'h11);
        repeat (100) @(negedge clk);
        rchk(8'hd8, 8'h00, 8'h08);
        repeat (40) @(negedge clk);
        rchk(8'hd8, 8'h08, 8'h08);
        i_core.wr(8'hd8, 8'h00);
        $display("watchdog done");
        i_core.wr(8'h89, 8'h5a);
        i_core.rst_hold(8);
        chk({7'h00, sys_reset}, 8'h01, "pin reset");
        c = 0;
        while (sys_reset === 1'b1 && c < 20) begin
            @(negedge clk);
            c++;
        end
        chk(8'(c >= 3 && c <= 10), 8'h01, "pin release");
        repeat (2) @(negedge clk);
        rchk(8'h89, 8'h00, 8'hff);
        $display("pin reset done");
        finish_test();
    end
endmodule : tb

bind mtwr_top mtwr_assertions i_chk (.clk(clk), .reset_n(reset_n), .rst_pin(rst_pin), .sfr_rd(sfr_rd),
    .sfr_wr(sfr_wr), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .sys_reset(sys_reset), .irq_req(irq_req), .irq_vector(irq_vector), .irq_high_prio(irq_high_prio));
